/* rtl/mdl_duty_limiter.sv */
// Duty limiter top: PID update, wind-up guards, duty limits, bridge drive, APB registers
// What this block does
// - Integral magnitude is clamped to a limit between 0 and 32767.
// - With saturation reset on, integral clears when proportional term exceeds max duty.
// - Error below dead-zone threshold forces duty target zero and clears integral.
// - Inside dead zone, stay until error exceeds twice the threshold.
// - Applied duty is signed, -600 full reverse to +600 full forward.
// - Forward drives A high, B low; reverse drives A low, B high.
// - Direction inversion swaps which bridge output goes high.
// - PWM carrier is selectable, 20 kHz or 5 kHz.
// - Asymmetric mode uses separate forward and reverse limits, else forward ones.
// - Duty magnitude clamps to the maximum duty of the current direction.
// - Duty magnitude rise per update interval is bounded by the acceleration step.
// - Current count times calibration in mA above ceiling reduces the duty.
// - On a direction change the duty holds zero for the brake duration.
// - Forward brake duration leaving forward, reverse duration leaving reverse.
// - Feedback outside absolute bounds applies the reduced maximum duty.
// - Error each interval is feedback minus target.
// - Integral sums the error; derivative is error minus previous error.
// - Motor off puts bridge in brake or coast by configuration.
`timescale 1ns/10ps
`default_nettype none
`include "mdl_params.svh"
module mdl_duty_limiter #(
    parameter int UPDATE_CYCLES = `MDL_UPDATE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] feedback,
    input wire logic [11:0] target,
    input wire logic [7:0] current_raw,
    output logic out_a,
    output logic out_a_oe,
    output logic out_b,
    output logic out_b_oe,
    output logic update_tick
);
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_r, ilim_r, kp_r, ki_r, kd_r, dz_r, maxd_r, acc_r;
    logic [31:0] maxc_r, cal_r, brk_r, oord_r, fbabs_r;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic acc_ph;
    mdl_pkg::mdl_duty_t duty_r;
    logic signed [15:0] integ_r;
    logic signed [12:0] perr_r;
    logic in_dz_r, last_neg_r, last_ok_r, oor_r, curlim_r;
    mdl_pkg::mdl_brk_state_t brk_st_r;
    logic [15:0] brk_cnt_r;
    logic [31:0] div_r;
    logic tick;

    assign acc_ph = psel & penable & ~pready;
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `MDL_A_CTRL: rd_mux = {26'h0, ctrl_r[5:0]};
            `MDL_A_ILIM: rd_mux = {17'h0, ilim_r[14:0]};
            `MDL_A_KP: rd_mux = {11'h0, kp_r[20:0]};
            `MDL_A_KI: rd_mux = {11'h0, ki_r[20:0]};
            `MDL_A_KD: rd_mux = {11'h0, kd_r[20:0]};
            `MDL_A_DZONE: rd_mux = {20'h0, dz_r[11:0]};
            `MDL_A_MAXDUTY: rd_mux = maxd_r & 32'h03ff_03ff;
            `MDL_A_MAXACC: rd_mux = acc_r & 32'h03ff_03ff;
            `MDL_A_MAXCUR: rd_mux = maxc_r;
            `MDL_A_CURCAL: rd_mux = {24'h0, cal_r[7:0]};
            `MDL_A_BRAKE: rd_mux = brk_r;
            `MDL_A_OORDUTY: rd_mux = oord_r & 32'h03ff_03ff;
            `MDL_A_FBABS: rd_mux = fbabs_r & 32'h0fff_0fff;
            `MDL_A_STATUS: rd_mux = {12'h0, curlim_r, oor_r, brk_st_r == mdl_pkg::MDL_HOLD, in_dz_r,
                                     5'h00, duty_r};
            `MDL_A_INTEG: rd_mux = {{16{integ_r[15]}}, integ_r};
            default: rd_hit = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle and ends the transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc_ph;
            pslverr <= acc_ph & ~rd_hit;
            if (acc_ph && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 32'h0; ilim_r <= 32'h0; kp_r <= 32'h0; ki_r <= 32'h0; kd_r <= 32'h0;
            dz_r <= 32'h0; maxd_r <= `MDL_RST_MAXDUTY; acc_r <= 32'h0; maxc_r <= 32'h0;
            cal_r <= 32'h0; brk_r <= 32'h0; oord_r <= 32'h0; fbabs_r <= `MDL_RST_FBABS;
        end else if (psel && penable && pready && pwrite) begin
            case (paddr)
                `MDL_A_CTRL: ctrl_r <= pwdata;
                `MDL_A_ILIM: ilim_r <= pwdata;
                `MDL_A_KP: kp_r <= pwdata;
                `MDL_A_KI: ki_r <= pwdata;
                `MDL_A_KD: kd_r <= pwdata;
                `MDL_A_DZONE: dz_r <= pwdata;
                `MDL_A_MAXDUTY: maxd_r <= pwdata;
                `MDL_A_MAXACC: acc_r <= pwdata;
                `MDL_A_MAXCUR: maxc_r <= pwdata;
                `MDL_A_CURCAL: cal_r <= pwdata;
                `MDL_A_BRAKE: brk_r <= pwdata;
                `MDL_A_OORDUTY: oord_r <= pwdata;
                `MDL_A_FBABS: fbabs_r <= pwdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control update interval divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 32'h0;
        end else begin
            div_r <= (div_r == 32'(UPDATE_CYCLES - 1)) ? 32'h0 : div_r + 32'h1;
        end
    end
    assign tick = div_r == 32'(UPDATE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    logic signed [12:0] err;
    logic [12:0] emag, dzv;
    logic dz_nxt, psat, neg, same, over, oor, rev;
    logic signed [16:0] isum;
    logic signed [15:0] integ_nxt;
    logic signed [29:0] p_full;
    logic signed [32:0] i_full;
    logic signed [30:0] d_full;
    logic signed [34:0] pid;
    logic [29:0] pmag;
    logic [9:0] pmax, cmag, lim, dmag, base, m1, m2, m3, accv;
    logic [10:0] step;
    logic [15:0] meas, dur;
    mdl_pkg::mdl_duty_t cand, duty_nxt;
    logic asym;

    assign asym = ctrl_r[`MDL_C_ASYM];
    always_comb begin
        err = $signed({1'b0, feedback}) - $signed({1'b0, target});
        emag = err[12] ? 13'(-err) : 13'(err);
        dzv = {1'b0, dz_r[11:0]};
        // Hysteresis keeps the loop from chattering on the edge of the zone
        dz_nxt = in_dz_r ? (emag <= {dzv[11:0], 1'b0}) : (emag < dzv);
        isum = 17'(integ_r) + 17'(err);
        if (isum > $signed({2'b00, ilim_r[14:0]})) begin
            integ_nxt = $signed({1'b0, ilim_r[14:0]});
        end else if (isum < -$signed({2'b00, ilim_r[14:0]})) begin
            integ_nxt = 16'(-$signed({2'b00, ilim_r[14:0]}));
        end else begin
            integ_nxt = 16'(isum);
        end
        p_full = 30'($signed({1'b0, kp_r[15:0]}) * err) >>> kp_r[20:16];
        pmag = p_full[29] ? 30'(-p_full) : 30'(p_full);
        pmax = (asym && p_full[29]) ? maxd_r[25:16] : maxd_r[9:0];
        psat = pmag > {20'h0, pmax};
        if (dz_nxt || (ctrl_r[`MDL_C_SATRST] && psat) || !ctrl_r[`MDL_C_ON]) begin
            integ_nxt = 16'sh0;
        end
        i_full = 33'($signed({1'b0, ki_r[15:0]}) * integ_nxt) >>> ki_r[20:16];
        d_full = 31'($signed({1'b0, kd_r[15:0]}) * (14'(err) - 14'(perr_r))) >>> kd_r[20:16];
        pid = 35'(p_full) + 35'(i_full) + 35'(d_full);
        if (pid > 35'sd600) begin
            cand = 11'sd600;
        end else if (pid < -35'sd600) begin
            cand = -11'sd600;
        end else begin
            cand = 11'(pid);
        end
        // Limits in fixed order
        if (dz_nxt) begin
            cand = 11'sd0;
        end
        neg = cand[10];
        cmag = neg ? 10'(-cand) : 10'(cand);
        oor = feedback < fbabs_r[11:0] || feedback > fbabs_r[27:16];
        if (oor) begin
            lim = (asym && neg) ? oord_r[25:16] : oord_r[9:0];
        end else begin
            lim = (asym && neg) ? maxd_r[25:16] : maxd_r[9:0];
        end
        m1 = (cmag > lim) ? lim : cmag;
        same = (duty_r == 11'sd0) || (duty_r[10] == neg);
        dmag = duty_r[10] ? 10'(-duty_r) : 10'(duty_r);
        base = same ? dmag : 10'h000;
        accv = (asym && neg) ? acc_r[25:16] : acc_r[9:0];
        step = {1'b0, base} + {1'b0, accv};
        // A zero step disables the acceleration limit; falling magnitude is never held back
        m2 = (accv != 10'h000 && {1'b0, m1} > step) ? step[9:0] : m1;
        meas = 16'(current_raw * cal_r[7:0]);
        over = ((asym && neg) ? maxc_r[31:16] : maxc_r[15:0]) != 16'h0 &&
               meas > ((asym && neg) ? maxc_r[31:16] : maxc_r[15:0]);
        if (over) begin
            m3 = (base == 10'h000) ? 10'h000 : ((m2 < base) ? m2 : base - 10'h001);
        end else begin
            m3 = m2;
        end
        duty_nxt = neg ? -$signed({1'b0, m3}) : $signed({1'b0, m3});
        rev = m3 != 10'h000 && last_ok_r && neg != last_neg_r;
        dur = last_neg_r ? brk_r[31:16] : brk_r[15:0];
        if (!asym) begin
            dur = brk_r[15:0];
        end
        if (brk_st_r == mdl_pkg::MDL_HOLD || (rev && dur != 16'h0) || !ctrl_r[`MDL_C_ON]) begin
            duty_nxt = 11'sd0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_r <= 11'sd0;
            integ_r <= 16'sh0;
            perr_r <= 13'sh0;
            in_dz_r <= 1'b0;
            oor_r <= 1'b0;
            curlim_r <= 1'b0;
        end else if (tick) begin
            duty_r <= duty_nxt;
            integ_r <= integ_nxt;
            perr_r <= err;
            in_dz_r <= dz_nxt;
            oor_r <= oor;
            curlim_r <= over;
        end
    end

    // Brake hold sequencer, counted in update intervals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_st_r <= mdl_pkg::MDL_RUN;
            brk_cnt_r <= 16'h0;
            last_neg_r <= 1'b0;
            last_ok_r <= 1'b0;
        end else if (tick) begin
            case (brk_st_r)
                mdl_pkg::MDL_RUN: begin
                    if (rev && dur != 16'h0 && ctrl_r[`MDL_C_ON]) begin
                        last_neg_r <= neg;
                        brk_cnt_r <= dur - 16'h1;
                        if (dur != 16'h1) begin
                            brk_st_r <= mdl_pkg::MDL_HOLD;
                        end
                    end else if (duty_nxt != 11'sd0) begin
                        last_neg_r <= duty_nxt[10];
                        last_ok_r <= 1'b1;
                    end
                end
                mdl_pkg::MDL_HOLD: begin
                    brk_cnt_r <= brk_cnt_r - 16'h1;
                    if (brk_cnt_r == 16'h1) begin
                        brk_st_r <= mdl_pkg::MDL_RUN;
                    end
                end
                default: brk_st_r <= mdl_pkg::MDL_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic pwm_on;
    logic [9:0] duty_mag;
    logic fwd_hi;
    assign duty_mag = duty_r[10] ? 10'(-duty_r) : 10'(duty_r);
    mdl_pwm u_pwm (
        .pclk(pclk),
        .presetn(presetn),
        .slow(ctrl_r[`MDL_C_SLOW]),
        .mag(duty_mag),
        .pwm_on(pwm_on)
    );

    assign fwd_hi = ~duty_r[10] ^ ctrl_r[`MDL_C_INV];
    // Off phase of the carrier brakes, so zero duty with the motor on is brake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
            out_a_oe <= 1'b0;
            out_b_oe <= 1'b0;
            update_tick <= 1'b0;
        end else begin
            update_tick <= tick;
            if (!ctrl_r[`MDL_C_ON]) begin
                out_a <= 1'b0;
                out_b <= 1'b0;
                out_a_oe <= ~ctrl_r[`MDL_C_COAST];
                out_b_oe <= ~ctrl_r[`MDL_C_COAST];
            end else begin
                out_a <= pwm_on & fwd_hi;
                out_b <= pwm_on & ~fwd_hi;
                out_a_oe <= 1'b1;
                out_b_oe <= 1'b1;
            end
        end
    end
endmodule // mdl_duty_limiter
`default_nettype wire

/* rtl/mdl_params.svh */
// Offsets, field positions, reset values and timing counts of the duty limiter
`ifndef MDL_PARAMS_SVH
`define MDL_PARAMS_SVH
`define MDL_A_CTRL 8'h00
`define MDL_A_ILIM 8'h04
`define MDL_A_KP 8'h08
`define MDL_A_KI 8'h0c
`define MDL_A_KD 8'h10
`define MDL_A_DZONE 8'h14
`define MDL_A_MAXDUTY 8'h18
`define MDL_A_MAXACC 8'h1c
`define MDL_A_MAXCUR 8'h20
`define MDL_A_CURCAL 8'h24
`define MDL_A_BRAKE 8'h28
`define MDL_A_OORDUTY 8'h2c
`define MDL_A_FBABS 8'h30
`define MDL_A_STATUS 8'h34
`define MDL_A_INTEG 8'h38
`define MDL_C_ON 0
`define MDL_C_INV 1
`define MDL_C_SLOW 2
`define MDL_C_ASYM 3
`define MDL_C_SATRST 4
`define MDL_C_COAST 5
`define MDL_DUTY_FULL 10'h258
`define MDL_ILIM_MAX 15'h7fff
`define MDL_RST_MAXDUTY 32'h0258_0258
`define MDL_RST_FBABS 32'h0fff_0000
`define MDL_CLK_HZ 250000000
`define MDL_UPDATE_US 1000
`define MDL_UPDATE_CYC (`MDL_UPDATE_US * (`MDL_CLK_HZ / 1000000))
`define MDL_PWM_FAST_HZ 20000
`define MDL_PWM_SLOW_HZ 5000
`define MDL_PWM_FAST_CYC (`MDL_CLK_HZ / `MDL_PWM_FAST_HZ)
`define MDL_PWM_SLOW_CYC (`MDL_CLK_HZ / `MDL_PWM_SLOW_HZ)
`define MDL_PWM_STEPS 600
`endif

/* rtl/mdl_pkg.sv */
// Types shared by the duty limiter files
`default_nettype none
package mdl_pkg;
    typedef logic signed [10:0] mdl_duty_t;
    typedef enum logic [0:0] {
        MDL_RUN = 1'b0,
        MDL_HOLD = 1'b1
    } mdl_brk_state_t;
endpackage
`default_nettype wire

/* rtl/mdl_pwm.sv */
// Carrier counter of 600 steps and duty compare for the bridge
`timescale 1ns/10ps
`default_nettype none
`include "mdl_params.svh"
module mdl_pwm (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic [9:0] mag,
    output logic pwm_on
);
    localparam logic [15:0] FAST_CYC = 16'(`MDL_PWM_FAST_CYC);
    localparam logic [15:0] SLOW_CYC = 16'(`MDL_PWM_SLOW_CYC);
    localparam logic [15:0] STEPS = 16'(`MDL_PWM_STEPS);
    logic [15:0] acc_r;
    logic [9:0] step_r;
    logic [15:0] per;
    logic [15:0] acc_sum;
    // Fractional stepping keeps the carrier exact although 600 does not divide the period
    assign per = slow ? SLOW_CYC : FAST_CYC;
    assign acc_sum = acc_r + STEPS;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= 16'h0000;
            step_r <= 10'h000;
        end else if (acc_sum >= per) begin
            acc_r <= acc_sum - per;
            step_r <= (step_r == 10'(`MDL_PWM_STEPS - 1)) ? 10'h000 : step_r + 10'h001;
        end else begin
            acc_r <= acc_sum;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_on <= 1'b0;
        end else begin
            pwm_on <= step_r < mag;
        end
    end
endmodule // mdl_pwm
`default_nettype wire

/* tb/mdl_bridge_model.sv */
// Behavioural H-bridge stage that counts driven-high cycles on each terminal
`timescale 1ns/10ps
`default_nettype none
module mdl_bridge_model (
    input wire logic pclk,
    input wire logic clr,
    input wire logic out_a,
    input wire logic out_a_oe,
    input wire logic out_b,
    input wire logic out_b_oe,
    output logic term_a,
    output logic term_b,
    output logic [31:0] cnt_a,
    output logic [31:0] cnt_b
);
    logic tgl_r = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // Floating terminals wander so a stale level never looks driven
    assign term_a = out_a_oe ? out_a : tgl_r;
    assign term_b = out_b_oe ? out_b : ~tgl_r;
    always_ff @(posedge pclk) begin
        tgl_r <= ~tgl_r;
        cnt_a <= clr ? 32'h0 : cnt_a + {31'h0, out_a_oe & out_a};
        cnt_b <= clr ? 32'h0 : cnt_b + {31'h0, out_b_oe & out_b};
    end
endmodule // mdl_bridge_model
`default_nettype wire

/* tb/mdl_duty_limiter_props.sv */
// Checker of bus handshake, bridge drive and update timing
`timescale 1ns/10ps
`default_nettype none
module mdl_duty_limiter_props #(
    parameter int UPDATE_CYCLES = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic out_a,
    input wire logic out_a_oe,
    input wire logic out_b,
    input wire logic out_b_oe,
    input wire logic update_tick
);
    logic [31:0] gap_r;
    logic seen_r;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= update_tick ? 32'h0 : gap_r + 32'h1;
            seen_r <= seen_r | update_tick;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        s_setup ##1 (psel && penable);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    wait_state_a: assert property (s_setup |=> !pready) else $error("early ready");
    ready_late_a: assert property (s_access |=> pready) else $error("ready not after one wait");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read nonzero");
    no_shoot_a: assert property (!(out_a && out_b)) else $error("both outputs high");
    drive_on_a: assert property (out_a || out_b |-> out_a_oe && out_b_oe) else $error("high undriven");
    coast_pair_a: assert property (out_a_oe == out_b_oe) else $error("enables differ");
    tick_period_a: assert property (update_tick && seen_r |-> gap_r == UPDATE_CYCLES - 1)
        else $error("tick spacing wrong");
    tick_due_a: assert property (seen_r |-> gap_r < UPDATE_CYCLES) else $error("tick missing");
endmodule // mdl_duty_limiter_props
bind mdl_duty_limiter mdl_duty_limiter_props #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_props (.pclk, .presetn,
    .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .out_a, .out_a_oe, .out_b, .out_b_oe, .update_tick);
`default_nettype wire

/* tb/motor_duty_limiter_tb.sv */
// Self-checking bench of the duty limiter
`timescale 1ns/10ps
`default_nettype none
`include "mdl_params.svh"
module motor_duty_limiter_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clr, e;
    logic out_a, out_a_oe, out_b, out_b_oe, update_tick, term_a, term_b;
    logic [7:0] paddr, current_raw;
    logic [11:0] feedback, target;
    logic [31:0] pwdata, prdata, r, cnt_a, cnt_b;
    logic [15:0] lf;
    int failures, checks, cyc;
    mdl_duty_limiter #(.UPDATE_CYCLES(64)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .feedback, .target, .current_raw, .out_a, .out_a_oe, .out_b, .out_b_oe,
        .update_tick);
    mdl_bridge_model u_br (.pclk, .clr, .out_a, .out_a_oe, .out_b, .out_b_oe, .term_a, .term_b, .cnt_a, .cnt_b);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int ed(input int x, input int m);
        return x > m ? m : (x < -m ? -m : x);
    endfunction
    task automatic end_sim;
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // Pins lag the duty by a few clocks, so counts get a small tolerance
    task automatic near(input logic [31:0] g, input int x);
        checks++;
        if ($isunknown(g) || int'(g) > x + 4 || int'(g) + 4 < x) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // Entered just after a rising edge; one idle cycle follows each transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk);
            while (!update_tick) @(posedge pclk);
        end
    endtask
    task automatic duty(input int n, input int x);
        tick(n);
        apb(1'b0, `MDL_A_STATUS, 32'h0);
        chk({21'h0, r[10:0]}, {21'h0, 11'(x)});
    endtask
    task automatic set_e(input int x);
        feedback <= 12'(2048 + x);
    endtask
    task automatic meas(input int n, input int xa, input int xb);
        clr <= 1'b1;
        @(posedge pclk) clr <= 1'b0;
        repeat (n) @(posedge pclk);
        near(cnt_a, xa);
        near(cnt_b, xb);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 99000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, clr} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        feedback = 12'h800;
        target = 12'h800;
        current_raw = 8'h00;
        lf = 16'ha3e1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `MDL_A_MAXDUTY, 32'h0);
        chk(r, `MDL_RST_MAXDUTY);
        apb(1'b0, `MDL_A_FBABS, 32'h0);
        chk(r, `MDL_RST_FBABS);
        apb(1'b0, 8'h3c, 32'h0);
        chk({r[30:0], e}, 32'h1);
        apb(1'b1, `MDL_A_ILIM, {lf, lf});
        apb(1'b0, `MDL_A_ILIM, 32'h0);
        chk(r, {17'h0, lf[14:0]});
        apb(1'b1, `MDL_A_KP, 32'h1);
        apb(1'b1, `MDL_A_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) begin
            lf = nxt(lf);
            feedback <= 12'(1024 + int'(lf[10:0]));
            current_raw <= lf[15:8];
            duty(2, ed(int'(lf[10:0]) - 1024, 600));
        end
        apb(1'b1, `MDL_A_MAXDUTY, 32'h0258_0064);
        set_e(500);
        duty(2, 100);
        set_e(-500);
        duty(2, -100);
        apb(1'b1, `MDL_A_CTRL, 32'h9);
        duty(2, -500);
        apb(1'b1, `MDL_A_MAXDUTY, 32'h0258_0258);
        apb(1'b1, `MDL_A_CTRL, 32'h1);
        set_e(100);
        duty(2, 100);
        meas(12500, 2083, 0);
        apb(1'b1, `MDL_A_CTRL, 32'h3);
        tick(1);
        meas(12500, 0, 2083);
        apb(1'b1, `MDL_A_CTRL, 32'h5);
        tick(1);
        meas(50000, 8333, 0);
        apb(1'b1, `MDL_A_CTRL, 32'h0);
        duty(1, 0);
        apb(1'b1, `MDL_A_MAXACC, 32'h0007_0007);
        apb(1'b1, `MDL_A_CTRL, 32'h1);
        duty(1, 7);
        duty(1, 14);
        apb(1'b1, `MDL_A_MAXACC, 32'h0);
        apb(1'b1, `MDL_A_DZONE, 32'hc8);
        duty(2, 0);
        chk({31'h0, r[16]}, 32'h1);
        set_e(300);
        duty(2, 0);
        set_e(500);
        duty(2, 500);
        apb(1'b1, `MDL_A_DZONE, 32'h0);
        apb(1'b1, `MDL_A_FBABS, 32'h07d0_0000);
        apb(1'b1, `MDL_A_OORDUTY, 32'h0032_0032);
        duty(2, 50);
        chk({31'h0, r[18]}, 32'h1);
        apb(1'b1, `MDL_A_FBABS, `MDL_RST_FBABS);
        apb(1'b1, `MDL_A_BRAKE, 32'h2);
        set_e(100);
        duty(2, 100);
        set_e(-100);
        duty(1, 0);
        chk({31'h0, r[17]}, 32'h1);
        duty(2, -100);
        apb(1'b1, `MDL_A_BRAKE, 32'h0);
        set_e(-100);
        // Current level first, so no update sees the calibration with a stale count
        current_raw <= 8'hc8;
        apb(1'b1, `MDL_A_MAXCUR, 32'h64);
        apb(1'b1, `MDL_A_CURCAL, 32'h1);
        duty(1, -99);
        duty(1, -98);
        apb(1'b1, `MDL_A_MAXCUR, 32'h0);
        apb(1'b1, `MDL_A_ILIM, 32'h32);
        apb(1'b1, `MDL_A_KI, 32'h1);
        duty(2, -150);
        apb(1'b0, `MDL_A_INTEG, 32'h0);
        chk(r, 32'hffff_ffce);
        apb(1'b1, `MDL_A_KP, 32'h8);
        apb(1'b1, `MDL_A_CTRL, 32'h11);
        duty(1, -600);
        apb(1'b0, `MDL_A_INTEG, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, `MDL_A_CTRL, 32'h20);
        tick(1);
        repeat (3) @(posedge pclk);
        chk({27'h0, term_a ^ term_b, out_a_oe, out_b_oe, out_a, out_b}, 32'h10);
        apb(1'b1, `MDL_A_CTRL, 32'h0);
        tick(1);
        repeat (3) @(posedge pclk);
        chk({27'h0, term_a | term_b, out_a_oe, out_b_oe, out_a, out_b}, 32'hc);
        end_sim();
    end
endmodule // motor_duty_limiter_tb
`default_nettype wire
